// ---- hw/hpaw_pkg.sv ----
// package: constants and types for the host port address write front end
package hpaw_pkg;
    // main clock rate and derived cycle counts
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    // least select-low width the host keeps in standard mode
    localparam int SEL_MIN_NS = 200;
    localparam int SEL_MIN_CYC = (SEL_MIN_NS + CLK_NS - 1) / CLK_NS;
    // slow clock tick rate for watchdog and beeper
    localparam int SLOW_HZ = 32_000;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam int SLOW_DIV_W = 11;
    // address reset value and mode codes
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [1:0] MODE_STD = 2'h0;
    localparam logic [1:0] MODE_EPP = 2'h1;
    localparam logic [1:0] MODE_ECP = 2'h2;
    // address write handshake states
    typedef enum logic [1:0] {HPAW_IDLE, HPAW_LATCH, HPAW_BUSY} hpaw_state_t;
endpackage

// ---- hw/hpaw_sync.sv ----
// two-flop level synchroniser
`timescale 1ns/1ns
module hpaw_sync
    import hpaw_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ---- hw/hpaw_top.sv ----
// host port address write front end with supply gating and slow tick
//
// Function
// - supply sense low: every output enable off, pins float.
// - supply sense high: output drivers enabled for normal operation.
// - bus interface logic runs from the main clock.
// - watchdog and beeper use a separate slow tick.
// - three cycle types in standard, EPP, ECP; here only address write.
// - latched address selects direction and target of data cycles.
// - standard mode: every address write accepted while supply sense high, busy never holds off.
// - EPP mode: on select fall latch byte, then raise busy.
`timescale 1ns/1ns
module hpaw_top
    import hpaw_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic SUPPLY_PRESENT_IN,
    input wire logic [1:0] MODE_IN,
    input wire logic HOST_SELECT_N_IN,
    input wire logic [7:0] HOST_DATA_IN,
    input wire logic SLOW_CLK_IN,
    output logic HOST_BUSY_OUT,
    output logic HOST_BUSY_OE_OUT,
    output logic [7:0] ADDR_OUT,
    output logic ADDR_VALID_OUT,
    output logic ADDR_STROBE_OUT,
    output logic ADDR_IS_READ_OUT,
    output logic SLOW_TICK_OUT,
    output logic OUTPUTS_EN_OUT
);
    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic sel_n_s;
    logic sup_s;
    logic slow_s;

    hpaw_sync #(.RST_VAL(1'b1)) u_sel
    (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .async_in(HOST_SELECT_N_IN),
        .sync_out(sel_n_s)
    );
    hpaw_sync #(.RST_VAL(1'b0)) u_sup
    (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .async_in(SUPPLY_PRESENT_IN),
        .sync_out(sup_s)
    );
    hpaw_sync #(.RST_VAL(1'b0)) u_slow
    (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .async_in(SLOW_CLK_IN),
        .sync_out(slow_s)
    );

    // ****************************************************************
    // edge detection and handshake
    // ****************************************************************
    logic sel_prev_q;
    logic slow_prev_q;
    hpaw_state_t state_q;
    hpaw_state_t state_d;
    logic [7:0] addr_q;
    logic valid_q;
    logic strobe_q;
    logic busy_q;
    logic tick_q;

    wire sel_fall = sel_prev_q & ~sel_n_s;
    wire is_epp = (MODE_IN == MODE_EPP);
    // data lines held valid by host when select falls
    // standard latch on fall
    wire take_addr = sel_fall & sup_s & (state_q == HPAW_IDLE);
    // edge of the slow clock seen through the synchroniser
    wire slow_rise = slow_s & ~slow_prev_q;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            HPAW_IDLE:
                if (take_addr)
                    state_d = is_epp ? HPAW_LATCH : HPAW_IDLE;
            HPAW_LATCH:
                state_d = HPAW_BUSY;
            // busy stays until host releases select or supply drops
            HPAW_BUSY:
                if (sel_n_s)
                    state_d = HPAW_IDLE;
        endcase
        if (!sup_s)
            state_d = HPAW_IDLE;
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            sel_prev_q <= 1'b1;
            slow_prev_q <= 1'b0;
            state_q <= HPAW_IDLE;
        end
        else
        begin
            sel_prev_q <= sel_n_s;
            slow_prev_q <= slow_s;
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            addr_q <= ADDR_RST;
            valid_q <= 1'b0;
            strobe_q <= 1'b0;
        end
        else
        begin
            strobe_q <= take_addr;
            if (take_addr)
            begin
                addr_q <= HOST_DATA_IN;
                valid_q <= 1'b1;
            end
        end
    end

    // standard mode never drives busy high
    always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            busy_q <= 1'b0;
        else
            busy_q <= (state_d == HPAW_BUSY);
    end

    // slow tick for watchdog and beeper, not the main time base
    always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            tick_q <= 1'b0;
        else
            tick_q <= slow_rise;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // float when supply absent
    assign OUTPUTS_EN_OUT = sup_s;
    assign HOST_BUSY_OE_OUT = sup_s;
    assign HOST_BUSY_OUT = busy_q;
    assign ADDR_OUT = addr_q;
    assign ADDR_VALID_OUT = valid_q;
    assign ADDR_STROBE_OUT = strobe_q;
    // bit 7 of the address marks a read; the rest name the target
    assign ADDR_IS_READ_OUT = addr_q[7];
    assign SLOW_TICK_OUT = tick_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    busy_after_latch_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        take_addr && is_epp |=> ##1 HOST_BUSY_OUT)
        else $error("busy not raised two cycles after EPP select fall");
    std_no_busy_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        take_addr && !is_epp |=> !HOST_BUSY_OUT)
        else $error("busy raised in standard address write");
    addr_capture_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        take_addr |=> ADDR_OUT == $past(HOST_DATA_IN) && ADDR_STROBE_OUT)
        else $error("address byte not latched");
    addr_hold_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        !take_addr |=> $stable(ADDR_OUT))
        else $error("address changed without a write");
    supply_off_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        !SUPPLY_PRESENT_IN [*3] |-> !HOST_BUSY_OE_OUT && !OUTPUTS_EN_OUT)
        else $error("driving while supply absent");
    supply_on_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        $rose(SUPPLY_PRESENT_IN) ##2 SUPPLY_PRESENT_IN |-> OUTPUTS_EN_OUT)
        else $error("drivers not enabled with supply present");
    busy_until_release_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        HOST_BUSY_OUT && !sel_n_s && sup_s |=> HOST_BUSY_OUT)
        else $error("busy dropped before select released");
    busy_release_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        HOST_BUSY_OUT && sel_n_s |=> !HOST_BUSY_OUT)
        else $error("busy held after select released");
    sync_delay_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        ##2 sel_n_s == $past(HOST_SELECT_N_IN, 2))
        else $error("select not delayed by two flops");
    slow_tick_a: assert property (
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        SLOW_TICK_OUT |=> !SLOW_TICK_OUT)
        else $error("slow tick longer than one cycle");
endmodule

// ---- tb/hpaw_host.sv ----
// host port model: drives address write cycles onto the port
`timescale 1ns/1ns
module hpaw_host
    import hpaw_pkg::*;
(
    input wire logic clk_in,
    input wire logic busy_in,
    input wire logic epp_in,
    output logic sel_n_out,
    output logic [7:0] data_out
);
    initial
    begin
        sel_n_out = 1'b1;
        data_out = 8'h00;
    end
    task automatic addr_write(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_in);
        data_out <= a;
        @(posedge clk_in);
        sel_n_out <= 1'b0;
        repeat (SEL_MIN_CYC + 2) @(posedge clk_in);
        while (epp_in && busy_in !== 1'b1 && n < 20)
        begin
            @(posedge clk_in);
            n++;
        end
        sel_n_out <= 1'b1;
        // one cycle after select is released the data lines change to the inverse of the byte
        @(posedge clk_in);
        data_out <= ~a;
        repeat (5) @(posedge clk_in);
    endtask
endmodule

// ---- tb/hpaw_top_tb.sv ----
// testbench: address writes in every mode, supply gating, slow tick
`timescale 1ns/1ns
module hpaw_top_tb
    import hpaw_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply = 1'b1;
    logic slow = 1'b0;
    logic [1:0] mode = MODE_STD;
    logic sel_n, busy, busy_oe, valid, strobe, is_rd, tick, en;
    logic [7:0] data, addr;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int samples_checked = 0;
    int ticks = 0;
    always #10 clk = ~clk;
    hpaw_top u_dut (.CLK_IN(clk), .RESET_N_IN(rst_n),
        .SUPPLY_PRESENT_IN(supply), .MODE_IN(mode),
        .HOST_SELECT_N_IN(sel_n), .HOST_DATA_IN(data),
        .SLOW_CLK_IN(slow), .HOST_BUSY_OUT(busy),
        .HOST_BUSY_OE_OUT(busy_oe), .ADDR_OUT(addr),
        .ADDR_VALID_OUT(valid), .ADDR_STROBE_OUT(strobe),
        .ADDR_IS_READ_OUT(is_rd), .SLOW_TICK_OUT(tick),
        .OUTPUTS_EN_OUT(en));
    hpaw_host u_host (.clk_in(clk), .busy_in(busy),
        .epp_in(mode == MODE_EPP), .sel_n_out(sel_n), .data_out(data));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
        if (tick === 1'b1)
            ticks++;
    // a strobe with nothing expected counts as a mismatch
    always @(posedge clk)
    begin
        logic [7:0] e;
        logic epp;
        if (strobe === 1'b1)
        begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : ~addr;
            epp = (mode == MODE_EPP);
            chk(addr, e);
            chk_bit(is_rd, e[7]);
            @(posedge clk);
            chk_bit(busy, epp);
        end
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    initial
    begin
        logic [7:0] a;
        void'($urandom(32'h8046A452));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk_bit(valid, 1'h0);
        for (int m = 0; m < 3; m++)
        begin
            @(posedge clk);
            mode <= 2'(m);
            repeat (4)
            begin
                a = 8'($urandom);
                exp_q.push_back(a);
                u_host.addr_write(a);
            end
        end
        chk_bit(valid, 1'h1);
        @(posedge clk);
        supply <= 1'b0;
        repeat (4) @(posedge clk);
        chk_bit(en, 1'h0);
        chk_bit(busy_oe, 1'h0);
        u_host.addr_write(8'h5A);
        @(posedge clk);
        supply <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit(en, 1'h1);
        chk_bit(busy_oe, 1'h1);
        @(posedge clk);
        mode <= MODE_EPP;
        exp_q.push_back(8'hC3);
        u_host.addr_write(8'hC3);
        chk_bit(busy, 1'h0);
        repeat (3)
        begin
            slow <= 1'b1;
            repeat (10) @(posedge clk);
            slow <= 1'b0;
            repeat (10) @(posedge clk);
        end
        chk(8'(ticks), 8'h03);
        chk(8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule
